// ==== bench/tcm_ch34_assertions.sv ====
// Port checker for the channel 3/4 mode block
`timescale 1ns/1ps
// ==========================================
// Checker module
module tcm_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic ch3_capture,
  input wire logic ch4_capture,
  input wire tcm_pkg::tcm_ocm_e ch3_compare_mode,
  input wire logic ch3_compare_preload_en,
  input wire logic ch3_fast_trigger_en,
  input wire tcm_pkg::tcm_ocm_e ch4_compare_mode,
  input wire logic ch4_compare_preload_en,
  input wire logic ch4_fast_trigger_en,
  input wire logic ch3_output_on,
  input wire logic ch4_output_on
);
  import tcm_pkg::*;
  // One clock domain, so one default
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Zero wait states, always OKAY
  bus_ready_a: assert property (hreadyout && !hresp)
    else $error("bus stall or error response");
  // Read data only moves on a taken read
  rdata_hold_a: assert property
    (!(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
    else $error("read data moved without a read");
  cap3_pulse_a: assert property (ch3_capture |=> !ch3_capture)
    else $error("channel 3 capture longer than one cycle");
  cap4_pulse_a: assert property (ch4_capture |=> !ch4_capture)
    else $error("channel 4 capture longer than one cycle");
  cap3_input_a: assert property (ch3_capture |-> !ch3_output_on)
    else $error("channel 3 captured while output");
  cap4_input_a: assert property (ch4_capture |-> !ch4_output_on)
    else $error("channel 4 captured while output");
  cap3_nocmp_a: assert property (ch3_capture |->
    ch3_compare_mode == TCM_OC_FROZEN && !ch3_fast_trigger_en
    && !ch3_compare_preload_en) else $error("channel 3 compare while input");
  cap4_nocmp_a: assert property (ch4_capture |->
    ch4_compare_mode == TCM_OC_FROZEN && !ch4_fast_trigger_en
    && !ch4_compare_preload_en) else $error("channel 4 compare while input");
  // Main scenarios reached
  cover property (ch3_capture);
  cover property (ch4_capture);
  cover property (ch3_output_on && ch4_output_on);
endmodule
bind tcm_ch34 tcm_chk chk_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .ch3_capture(ch3_capture),
  .ch4_capture(ch4_capture), .ch3_compare_mode(ch3_compare_mode),
  .ch3_compare_preload_en(ch3_compare_preload_en),
  .ch3_fast_trigger_en(ch3_fast_trigger_en),
  .ch4_compare_mode(ch4_compare_mode),
  .ch4_compare_preload_en(ch4_compare_preload_en),
  .ch4_fast_trigger_en(ch4_fast_trigger_en),
  .ch3_output_on(ch3_output_on), .ch4_output_on(ch4_output_on));

// ==== bench/tcm_ch34_tb.sv ====
// Self-checking bench for the channel 3/4 mode block
`timescale 1ns/1ps
`include "tcm_defines.svh"
// ==========================================
// Bench top
module tcm_ch34_tb;
  import tcm_pkg::*;
  localparam logic [7:0] MO = `TCM_MODE_OFS;
  localparam logic [7:0] EO = `TCM_ENABLE_OFS;
  localparam logic [7:0] SO = `TCM_STATUS_OFS;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp;
  // Capture sources: pin three, pin four, trigger
  logic t3 = 1'b0;
  logic t4 = 1'b0;
  logic tg = 1'b0;
  logic c3, c4, p3, p4, f3, f4, o3, o4;
  tcm_ocm_e m3, m4;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  int n3 = 0;
  int n4 = 0;
  tcm_ch34 uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .pin_input_three(t3), .pin_input_four(t4),
    .internal_trigger_in(tg), .ch3_capture(c3), .ch4_capture(c4),
    .ch3_compare_mode(m3), .ch3_compare_preload_en(p3),
    .ch3_fast_trigger_en(f3), .ch4_compare_mode(m4),
    .ch4_compare_preload_en(p4), .ch4_fast_trigger_en(f4),
    .ch3_output_on(o3), .ch4_output_on(o4));
  always #5 hclk = ~hclk;
  // Count captures; cut a hang short
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    n3 <= n3 + int'(c3 === 1'b1);
    n4 <= n4 + int'(c4 === 1'b1);
    if (cyc == 40000)
    begin
      n_fail++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int got, input int lo, input int hi);
    n_checks++;
    if (got < lo || got > hi)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h range %h %h", $time, got, lo, hi);
    end
  endtask
  // One AHB single transfer, waits for ready
  task automatic bus(input logic [7:0] a, input logic w,
    input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0, q);
    chk(q, e);
  endtask
  task automatic pins(input logic v, input int n);
    t3 <= v;
    t4 <= v;
    repeat (n) @(posedge hclk);
  endtask
  // Reset values, widths, unmapped place, direction lock
  task automatic t_regs();
    rd(MO, 32'h0);
    rd(EO, 32'h0);
    rd(SO, 32'h0);
    wr(MO, 32'hFFFFFFFF);
    rd(MO, 32'h0000FFFF);
    wr(EO, 32'hFFFFFFFF);
    rd(EO, 32'h00003300);
    wr(MO, 32'h0);
    rd(MO, 32'h00000303);
    wr(EO, 32'h0);
    wr(MO, 32'h0);
    wr(8'h0C, 32'hFFFFFFFF);
    rd(8'h0C, 32'h0);
    $display("regs done");
  endtask
  // Every compare mode; output gating; input hides compare
  task automatic t_cmp();
    logic [2:0] mm;
    int b;
    for (int m = 0; m < 8; m++)
    begin
      mm = 3'(m);
      wr(MO, {16'h0, 1'b0, mm, 4'h8, 1'b0, mm, 4'h4});
      repeat (3) @(posedge hclk);
      chk({27'h0, m3, p3, f3}, {27'h0, mm, 2'h1});
      chk({27'h0, m4, p4, f4}, {27'h0, mm, 2'h2});
    end
    wr(EO, 32'h1100);
    repeat (3) @(posedge hclk);
    chk({30'h0, o3, o4}, 32'h3);
    b = n3 + n4;
    pins(1'b1, 10);
    pins(1'b0, 10);
    chk(32'(n3 + n4 - b), 32'h0);
    wr(EO, 32'h0);
    wr(MO, 32'h7D7D);
    repeat (3) @(posedge hclk);
    chk({22'h0, m3, p3, f3, m4, p4, f4}, 32'h0);
    rd(MO, 32'h00007D7D);
    $display("compare done");
  endtask
  // Filter latency for all codes, both channels
  task automatic t_filt();
    int d[16] = '{1, 1, 1, 1, 2, 2, 4, 4, 4, 8, 16, 16, 16, 32, 32, 32};
    int n[16] = '{1, 2, 8, 8, 6, 8, 6, 8, 8, 8, 5, 6, 8, 5, 6, 8};
    int k3, k4, b;
    logic [3:0] c;
    wr(MO, 32'h2121);
    wr(EO, 32'h1100);
    b = n3;
    pins(1'b1, 7);
    pins(1'b0, 20);
    chk(32'(n3 - b), 32'h0);
    for (int i = 0; i < 16; i++)
    begin
      c = 4'(i);
      wr(MO, {16'h0, c, 4'h1, c, 4'h1});
      t3 <= 1'b1;
      t4 <= 1'b1;
      k3 = -1;
      k4 = -1;
      for (int j = 0; j < 300; j++)
      begin
        @(negedge hclk);
        if (c3 === 1'b1 && k3 < 0)
          k3 = j;
        if (c4 === 1'b1 && k4 < 0)
          k4 = j;
      end
      @(posedge hclk);
      chk_rng(k3, (n[i] - 1) * d[i] + 3, n[i] * d[i] + 2);
      chk_rng(k4, (n[i] - 1) * d[i] + 3, n[i] * d[i] + 2);
      pins(1'b0, 300);
    end
    $display("filter done");
  endtask
  // Source selection for every input direction code
  task automatic t_route();
    int b3, b4;
    logic [1:0] dd;
    for (int d = 1; d < 4; d++)
      for (int s = 0; s < 3; s++)
      begin
        dd = 2'(d);
        wr(EO, 32'h0);
        wr(MO, {16'h0, 6'h0, dd, 6'h0, dd});
        wr(EO, 32'h1100);
        repeat (5) @(posedge hclk);
        chk({30'h0, o3, o4}, 32'h0);
        b3 = n3;
        b4 = n4;
        tg <= (s == 2);
        t3 <= (s == 0);
        t4 <= (s == 1);
        repeat (20) @(posedge hclk);
        tg <= 1'b0;
        pins(1'b0, 20);
        chk(32'(n3 - b3), 32'(s == d - 1));
        chk(32'(n4 - b4), 32'(s == (d == 1 ? 1 : d == 2 ? 0 : 2)));
      end
    $display("route done");
  endtask
  // Prescaler codes and sticky status
  task automatic t_psc();
    int b3, b4;
    logic [1:0] pp;
    for (int p = 0; p < 4; p++)
    begin
      pp = 2'(p);
      wr(EO, 32'h0);
      wr(MO, {16'h0, 4'h0, pp, 2'h1, 4'h0, pp, 2'h1});
      wr(EO, 32'h1100);
      repeat (5) @(posedge hclk);
      b3 = n3;
      b4 = n4;
      repeat (8)
      begin
        pins(1'b1, 4);
        pins(1'b0, 4);
      end
      repeat (10) @(posedge hclk);
      chk(32'(n3 - b3), 32'(8 >> p));
      chk(32'(n4 - b4), 32'(8 >> p));
    end
    rd(SO, 32'h0000000C);
    wr(SO, 32'h0000000C);
    rd(SO, 32'h0);
    $display("prescale done");
  endtask
  // Polarity picks the edge; enable gates capture
  task automatic t_pol();
    int b3, b4;
    wr(EO, 32'h0);
    wr(MO, 32'h0101);
    wr(EO, 32'h3300);
    repeat (10) @(posedge hclk);
    b3 = n3;
    b4 = n4;
    pins(1'b1, 10);
    chk(32'(n3 - b3), 32'h0);
    rd(SO, 32'h0000000F);
    pins(1'b0, 10);
    chk(32'(n3 + n4 - b3 - b4), 32'h2);
    wr(EO, 32'h0);
    pins(1'b1, 10);
    pins(1'b0, 10);
    chk(32'(n3 + n4 - b3 - b4), 32'h2);
    $display("polarity done");
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_cmp();
    t_filt();
    t_route();
    t_psc();
    t_pol();
    stop_test();
  end
endmodule

// ==== design/tcm_ch34.sv ====
// Channel 3/4 capture/compare mode register, input filters and prescalers
// Functional notes
// - Filter passes level after N agreeing samples
// - Full-rate codes: none, two, eight samples
// - Divided codes sample at clock/2..clock/32
// - Filter and prescaler only for input
// - Prescaler captures every 1, 2, 4, 8 events
// - Channel 4 source: out, pin4, pin3, trigger
// - Channel 3 source: out, pin3, pin4, trigger
// - Channel 3 compare mode, output only
// - Channel 3 preload and fast bits, output
// - Channel 3 filter and prescaler fields
// - Compare mode encoding frozen through PWM
// - Polarity chooses rising or falling capture
// - Enable gates capture or compare output
`timescale 1ns/1ps
`include "tcm_defines.svh"
module tcm_ch34 (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic pin_input_three,
  input wire logic pin_input_four,
  input wire logic internal_trigger_in,
  output logic ch3_capture,
  output logic ch4_capture,
  output tcm_pkg::tcm_ocm_e ch3_compare_mode,
  output logic ch3_compare_preload_en,
  output logic ch3_fast_trigger_en,
  output tcm_pkg::tcm_ocm_e ch4_compare_mode,
  output logic ch4_compare_preload_en,
  output logic ch4_fast_trigger_en,
  output logic ch3_output_on,
  output logic ch4_output_on
);
  import tcm_pkg::*;

  // Filter code to {divider shift, sample count}
  function automatic logic [6:0] filt_decode(input logic [3:0] code);
    logic [6:0] r;
    r = {3'h0, 4'h1};
    unique case (code)
      4'h0: r = {3'h0, 4'h1};
      4'h1: r = {3'h0, 4'h2};
      4'h2: r = {3'h0, 4'h8};
      4'h3: r = {3'h0, 4'h8};
      4'h4: r = {3'h1, 4'h6};
      4'h5: r = {3'h1, 4'h8};
      4'h6: r = {3'h2, 4'h6};
      4'h7: r = {3'h2, 4'h8};
      4'h8: r = {3'h2, 4'h8};
      4'h9: r = {3'h3, 4'h8};
      4'hA: r = {3'h4, 4'h5};
      4'hB: r = {3'h4, 4'h6};
      4'hC: r = {3'h4, 4'h8};
      4'hD: r = {3'h5, 4'h5};
      4'hE: r = {3'h5, 4'h6};
      4'hF: r = {3'h5, 4'h8};
    endcase
    return r;
  endfunction

  // ==========================================================
  // Register bus slave
  // ==========================================================
  logic [15:0] mode_ff;         // Mode register
  logic [15:0] nxt_mode;
  logic [15:0] enable_ff;       // Enable and polarity register
  logic [15:0] nxt_enable;
  logic [1:0] cap_seen_ff;      // Sticky capture flags
  logic [1:0] nxt_cap_seen;
  logic wr_pend_ff;             // Write data phase pending
  logic nxt_wr_pend;
  logic [7:0] wr_addr_ff;       // Latched write address
  logic [7:0] nxt_wr_addr;
  logic [31:0] hrdata_ff;       // Read data for data phase
  logic [31:0] nxt_hrdata;
  logic hreadyout_ff;           // Ready flop, never stalls
  logic hresp_ff;               // Response flop, always OKAY
  wire logic [1:0] lvl_ff;      // Filtered levels, per channel
  wire logic [1:0] cap_ff;      // Capture pulses, per channel
  // Compare view {ch4, ch3}, each {on, fast, preload, mode}
  wire logic [11:0] oc_cfg;
  logic addr_ok;
  logic [15:0] wdat;

  // Bus decode, register writes and read mux
  always_comb
  begin
    addr_ok = hsel && htrans[1] && hready;
    wdat = hwdata[15:0];
    nxt_mode = mode_ff;
    nxt_enable = enable_ff;
    nxt_wr_pend = addr_ok && hwrite;
    nxt_wr_addr = addr_ok ? haddr : wr_addr_ff;
    nxt_hrdata = hrdata_ff;
    // Sticky flags: a capture in the clearing cycle wins
    nxt_cap_seen = cap_seen_ff;
    if (wr_pend_ff)
    begin
      unique case (wr_addr_ff)
        `TCM_MODE_OFS:
        begin
          nxt_mode = wdat;
          if (enable_ff[`TCM_CH3_EN_BIT])
            nxt_mode[`TCM_CH3_DIR_HI:`TCM_CH3_DIR_LO] =
              mode_ff[`TCM_CH3_DIR_HI:`TCM_CH3_DIR_LO];
          if (enable_ff[`TCM_CH4_EN_BIT])
            nxt_mode[`TCM_CH4_DIR_HI:`TCM_CH4_DIR_LO] =
              mode_ff[`TCM_CH4_DIR_HI:`TCM_CH4_DIR_LO];
        end
        `TCM_ENABLE_OFS:
          nxt_enable = wdat & 16'h3300;
        `TCM_STATUS_OFS:
          nxt_cap_seen = cap_seen_ff &
            ~wdat[`TCM_ST_CAP4_BIT:`TCM_ST_CAP3_BIT];
        default:
          nxt_mode = mode_ff;
      endcase
    end
    nxt_cap_seen = nxt_cap_seen | cap_ff;
    // Reads answered with zero wait states
    if (addr_ok && !hwrite)
    begin
      unique case (haddr)
        `TCM_MODE_OFS: nxt_hrdata = {16'h0000, mode_ff};
        `TCM_ENABLE_OFS: nxt_hrdata = {16'h0000, enable_ff};
        `TCM_STATUS_OFS:
          nxt_hrdata = {28'h0000000, cap_seen_ff, lvl_ff};
        default: nxt_hrdata = 32'h00000000;
      endcase
    end
  end

  // Bus registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mode_ff <= `TCM_MODE_RST;
      enable_ff <= `TCM_ENABLE_RST;
      cap_seen_ff <= 2'b00;
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      hrdata_ff <= 32'h00000000;
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end
    else
    begin
      mode_ff <= nxt_mode;
      enable_ff <= nxt_enable;
      cap_seen_ff <= nxt_cap_seen;
      wr_pend_ff <= nxt_wr_pend;
      wr_addr_ff <= nxt_wr_addr;
      hrdata_ff <= nxt_hrdata;
      // No wait states, no error: kept in flops for clean outputs
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end
  end

  assign hrdata = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp = hresp_ff;

  // ==========================================================
  // Pin synchronisers and sampling divider
  // ==========================================================
  logic [1:0] pin_s1_ff;        // First stage, read only by second
  logic [1:0] pin_s2_ff;        // Safe pin levels {four, three}
  logic [`TCM_DIV_W-1:0] div_ff; // Free-running sample divider
  logic [`TCM_DIV_W-1:0] nxt_div;

  // Divider next value
  always_comb
  begin
    nxt_div = div_ff + 5'h01;
  end

  // Synchroniser and divider registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_s1_ff <= 2'b00;
      pin_s2_ff <= 2'b00;
      div_ff <= 5'h00;
    end
    else
    begin
      pin_s1_ff <= {pin_input_four, pin_input_three};
      pin_s2_ff <= pin_s1_ff;
      div_ff <= nxt_div;
    end
  end

  // ==========================================================
  // Per-channel input path, index 0 is channel 3, 1 is channel 4
  // ==========================================================
  logic [3:0] filt_code [2];
  logic [1:0] psc_code [2];
  logic [1:0] dir_code [2];
  tcm_pair_t en_bit;
  tcm_pair_t pol_bit;
  logic [4:0] ocf_code [2];     // {fast, preload, mode} fields

  assign filt_code[0] = mode_ff[`TCM_CH3_FILT_HI:`TCM_CH3_FILT_LO];
  assign filt_code[1] = mode_ff[`TCM_CH4_FILT_HI:`TCM_CH4_FILT_LO];
  assign psc_code[0] = mode_ff[`TCM_CH3_PSC_HI:`TCM_CH3_PSC_LO];
  assign psc_code[1] = mode_ff[`TCM_CH4_PSC_HI:`TCM_CH4_PSC_LO];
  assign dir_code[0] = mode_ff[`TCM_CH3_DIR_HI:`TCM_CH3_DIR_LO];
  assign dir_code[1] = mode_ff[`TCM_CH4_DIR_HI:`TCM_CH4_DIR_LO];
  assign en_bit = {enable_ff[`TCM_CH4_EN_BIT], enable_ff[`TCM_CH3_EN_BIT]};
  assign pol_bit = {enable_ff[`TCM_CH4_POL_BIT],
                    enable_ff[`TCM_CH3_POL_BIT]};
  assign ocf_code[0] = {mode_ff[`TCM_CH3_FAST_BIT],
                        mode_ff[`TCM_CH3_PRE_BIT],
                        mode_ff[`TCM_CH3_OCM_HI:`TCM_CH3_OCM_LO]};
  assign ocf_code[1] = {mode_ff[`TCM_CH4_FAST_BIT],
                        mode_ff[`TCM_CH4_PRE_BIT],
                        mode_ff[`TCM_CH4_OCM_HI:`TCM_CH4_OCM_LO]};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_ch
      logic [3:0] run_ff;       // Agreeing samples so far
      logic [3:0] nxt_run;
      logic [2:0] evt_ff;       // Prescaler event count
      logic [2:0] nxt_evt;
      logic prev_ff;            // Previous polarised level
      logic nxt_lvl;
      logic nxt_cap;
      logic src;
      logic is_in;
      logic samp;
      logic [6:0] fd;
      logic [2:0] limit;
      logic pol_lvl;
      logic lvl_ch_ff;          // Filtered level
      logic cap_ch_ff;          // Capture pulse
      logic [5:0] oc_ch_ff;     // Compare view {on, fast, preload, mode}
      logic [5:0] nxt_oc;

      // Source select, filter, edge detect, prescaler, compare view
      always_comb
      begin
        fd = filt_decode(filt_code[gi]);
        unique case (tcm_dir_e'(dir_code[gi]))
          TCM_DIR_OUT: src = 1'b0;
          TCM_DIR_OWN: src = pin_s2_ff[gi];
          TCM_DIR_NBR: src = pin_s2_ff[1-gi];
          TCM_DIR_TRG: src = internal_trigger_in;
        endcase
        is_in = dir_code[gi] != 2'b00;
        samp = (div_ff & ((5'h01 << fd[6:4]) - 5'h01)) == 5'h00;
        nxt_run = run_ff;
        nxt_lvl = lvl_ff[gi];
        // Count agreeing samples of new level
        if (!is_in)
        begin
          nxt_run = 4'h0;
          nxt_lvl = 1'b0;
        end
        else if (samp)
        begin
          if (src == lvl_ff[gi])
            nxt_run = 4'h0;
          else if (run_ff + 4'h1 >= fd[3:0])
          begin
            nxt_lvl = src;
            nxt_run = 4'h0;
          end
          else
            nxt_run = run_ff + 4'h1;
        end
        pol_lvl = nxt_lvl ^ pol_bit[gi];
        // Capture on every 1, 2, 4 or 8 events
        limit = 3'((4'h1 << psc_code[gi]) - 4'h1);
        nxt_evt = evt_ff;
        nxt_cap = 1'b0;
        if (!is_in || !en_bit[gi])
          nxt_evt = 3'h0;
        else if (pol_lvl && !prev_ff)
        begin
          if (evt_ff >= limit)
          begin
            nxt_evt = 3'h0;
            nxt_cap = 1'b1;
          end
          else
            nxt_evt = evt_ff + 3'h1;
        end
        // Compare fields only in output direction
        nxt_oc = 6'h00;
        if (!is_in)
          nxt_oc = {en_bit[gi], ocf_code[gi]};
      end

      // Channel input registers
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          run_ff <= 4'h0;
          evt_ff <= 3'h0;
          prev_ff <= 1'b0;
          lvl_ch_ff <= 1'b0;
          cap_ch_ff <= 1'b0;
          oc_ch_ff <= 6'h00;
        end
        else
        begin
          run_ff <= nxt_run;
          evt_ff <= nxt_evt;
          prev_ff <= pol_lvl;
          lvl_ch_ff <= nxt_lvl;
          cap_ch_ff <= nxt_cap;
          oc_ch_ff <= nxt_oc;
        end
      end

      // Each channel drives only its own bits of the shared nets
      assign lvl_ff[gi] = lvl_ch_ff;
      assign cap_ff[gi] = cap_ch_ff;
      assign oc_cfg[6*gi +: 6] = oc_ch_ff;
    end
  endgenerate

  // ==========================================================
  // Outputs, all straight from channel flops
  // ==========================================================
  assign ch3_capture = cap_ff[0];
  assign ch4_capture = cap_ff[1];
  assign ch3_compare_mode = tcm_ocm_e'(oc_cfg[2:0]);
  assign ch3_compare_preload_en = oc_cfg[3];
  assign ch3_fast_trigger_en = oc_cfg[4];
  assign ch3_output_on = oc_cfg[5];
  assign ch4_compare_mode = tcm_ocm_e'(oc_cfg[8:6]);
  assign ch4_compare_preload_en = oc_cfg[9];
  assign ch4_fast_trigger_en = oc_cfg[10];
  assign ch4_output_on = oc_cfg[11];
endmodule

// ==== shared/tcm_defines.svh ====
// Offsets, field positions, reset values and divider width of the channel block
`ifndef TCM_DEFINES_SVH
`define TCM_DEFINES_SVH
// Register byte offsets
`define TCM_MODE_OFS 8'h00
`define TCM_ENABLE_OFS 8'h04
`define TCM_STATUS_OFS 8'h08
// Mode register fields, channel 4
`define TCM_CH4_FILT_HI 15
`define TCM_CH4_FILT_LO 12
`define TCM_CH4_PSC_HI 11
`define TCM_CH4_PSC_LO 10
`define TCM_CH4_DIR_HI 9
`define TCM_CH4_DIR_LO 8
`define TCM_CH4_OCM_HI 14
`define TCM_CH4_OCM_LO 12
`define TCM_CH4_PRE_BIT 11
`define TCM_CH4_FAST_BIT 10
// Mode register fields, channel 3
`define TCM_CH3_FILT_HI 7
`define TCM_CH3_FILT_LO 4
`define TCM_CH3_PSC_HI 3
`define TCM_CH3_PSC_LO 2
`define TCM_CH3_DIR_HI 1
`define TCM_CH3_DIR_LO 0
`define TCM_CH3_OCM_HI 6
`define TCM_CH3_OCM_LO 4
`define TCM_CH3_PRE_BIT 3
`define TCM_CH3_FAST_BIT 2
// Enable register fields
`define TCM_CH3_EN_BIT 8
`define TCM_CH3_POL_BIT 9
`define TCM_CH4_EN_BIT 12
`define TCM_CH4_POL_BIT 13
// Status register fields
`define TCM_ST_LVL3_BIT 0
`define TCM_ST_LVL4_BIT 1
`define TCM_ST_CAP3_BIT 2
`define TCM_ST_CAP4_BIT 3
// Reset values
`define TCM_MODE_RST 16'h0000
`define TCM_ENABLE_RST 16'h0000
// Sampling divider counter width
`define TCM_DIV_W 5
`endif

// ==== shared/tcm_pkg.sv ====
// Types shared by the channel 3/4 mode block
package tcm_pkg;
  // Channel direction and source
  typedef enum logic [1:0] {
    TCM_DIR_OUT = 2'b00,
    TCM_DIR_OWN = 2'b01,
    TCM_DIR_NBR = 2'b10,
    TCM_DIR_TRG = 2'b11
  } tcm_dir_e;
  // Output compare modes
  typedef enum logic [2:0] {
    TCM_OC_FROZEN = 3'b000,
    TCM_OC_SET = 3'b001,
    TCM_OC_CLR = 3'b010,
    TCM_OC_TOGGLE = 3'b011,
    TCM_OC_FORCE_LO = 3'b100,
    TCM_OC_FORCE_HI = 3'b101,
    TCM_OC_PWM1 = 3'b110,
    TCM_OC_PWM2 = 3'b111
  } tcm_ocm_e;
  // Two-channel vectors
  typedef logic [1:0] tcm_pair_t;
endpackage
